// ---- src/asp_pkg.sv ----
// Constants, register map and field layout of the asynchronous serial port.
// Functional notes
// - Bit rate is system clock divided by multiplier times 16-bit divisor.
// - Data address reads the received character and writes a transmit one.
// - Divisor low and high bytes are reachable only with divisor access set.
// - Line-control bit 7 maps shared addresses to divisor or normal registers.
// - Enable bits gate modem, line status, transmit empty and data sources.
// - Identification bit 0 is low while an enabled interrupt is pending.
// - Identification codes: 011, then 010 and 110, then 001, then 000.
// - Timeout after 4 idle character times with data held; read clears it.
// - Transmit queue empty sets status bit 5; draining or flushing the queue sets the transmit-empty source.
// - Data available fires at trigger 1, 4, 8 or 14 bytes; reset code 3.
// - Queue-control bits 2 and 1 flush transmit and receive queues.
// - Shared address reads identification and writes queue control.
// - Line-control bit 6 forces the serial output low as a break.
// - Parity on bit 3 appends and checks parity; bit 4 selects even.
// - Stick parity sends and expects zero when even, else one.
// - Stop-bit select zero sends one stop bit, one sends two.
// - Word length 5 to 8 bits, reset 8; 5-bit with two stops uses 1.5.
// - Status bit 7 flags any received parity, framing or break; read clears.
// - Status bit 6 is set while queue and shifter are empty; resets to one.
// - Break sets bit 4, queues one zero character, waits for a start bit.
// - Framing error bit 3 flags the head character; read clears it.
// - Parity error bit 2 flags the head character.
// - Baud multiplier register resets to 0x10, reachable with divisor access.
// - Full receive queue plus a new character sets overrun, queue intact.
// - Data ready bit 0 is set while the receive queue holds a character.
// - Both queues hold 16 entries.
package asp_pkg;
  localparam logic [15:0] ADDR_DATA = 16'h2500;
  localparam logic [15:0] ADDR_IER  = 16'h2501;
  localparam logic [15:0] ADDR_IIR  = 16'h2502;
  localparam logic [15:0] ADDR_LCR  = 16'h2503;
  localparam logic [15:0] ADDR_LSR  = 16'h2505;
  localparam logic [15:0] ADDR_XCR  = 16'h2507;
  localparam int LCR_DIVISOR_ACCESS_SELECT = 7;
  localparam int LCR_BRK  = 6;
  localparam int LCR_STK  = 5;
  localparam int LCR_EPS  = 4;
  localparam int LCR_PEN  = 3;
  localparam int LCR_STB  = 2;
  localparam int IER_MS   = 3;
  localparam int IER_LS   = 2;
  localparam int IER_TE   = 1;
  localparam int IER_RA   = 0;
  localparam int FCR_TXF  = 2;
  localparam int FCR_RXF  = 1;
  localparam int FCR_TRH  = 7;
  localparam int FCR_TRL  = 6;
  localparam logic [7:0] LCR_RST  = 8'h03;
  localparam logic [7:0] XCR_RST  = 8'h10;
  localparam logic [1:0] TRIG_RST = 2'h3;
  localparam logic [2:0] IID_LS = 3'h3;
  localparam logic [2:0] IID_RA = 3'h2;
  localparam logic [2:0] IID_TO = 3'h6;
  localparam logic [2:0] IID_TE = 3'h1;
  localparam logic [2:0] IID_MS = 3'h0;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL = 5'h10;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;
  localparam logic [2:0] MIN_BITS_M1 = 3'h4;
  localparam logic [3:0] MIN_FRAME = 4'h7;
endpackage : asp_pkg

// ---- src/asp_uart.sv ----
// Asynchronous serial transceiver with 16-entry queues and byte registers.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module asp_uart
  import asp_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        rxd_in,
  output logic      [7:0]  rdata_out,
  output logic             txd_out,
  output logic             irq_out
);
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
    TX_PAR  = 5'b01000, TX_STOP  = 5'b10000
  } asp_tx_e;
  typedef enum logic [5:0] {
    RX_IDLE = 6'b000001, RX_START = 6'b000010, RX_DATA = 6'b000100,
    RX_PAR  = 6'b001000, RX_STOP  = 6'b010000, RX_BRK  = 6'b100000
  } asp_rx_e;

  function automatic logic par_calc(input logic [7:0] d,
                                    input logic [7:0] frame_format_control);
    logic [7:0] mask;
    mask = 8'hFF >> (2'h3 - frame_format_control[1:0]);
    if (frame_format_control[LCR_STK]) par_calc = ~frame_format_control[LCR_EPS];
    else par_calc = (^(d & mask)) ^ ~frame_format_control[LCR_EPS];
  endfunction : par_calc

  logic [7:0]  dll, divisor_high_byte, baud_multiplier, frame_format_control;
  logic [3:0]  irq_enable_mask;
  logic [1:0]  trig;
  logic [15:0] div_cnt;
  logic [9:0]  bt_cnt, tx_tcnt, rx_tcnt;
  logic [7:0]  tx_mem [FIFO_DEPTH];
  logic [10:0] rx_mem [FIFO_DEPTH];
  logic [3:0]  tx_wp, tx_rp, rx_wp, rx_rp;
  logic [4:0]  tx_cnt, rx_cnt;
  asp_tx_e     tx_st;
  asp_rx_e     rx_st;
  logic [7:0]  tx_shift, rx_shift;
  logic [2:0]  tx_bitn, rx_bitn;
  logic        tx_par, rx_par, rx_allz, rx_s1, rx_s2, rx_prev;
  logic        oe_f, pe_f, fe_f, bi_f, err_f, tx_queue_empty_irq, head_new;
  logic [7:0]  to_cnt;

  wire divisor_access_select    = frame_format_control[LCR_DIVISOR_ACCESS_SELECT];
  wire sel_dat = addr_in == ADDR_DATA;
  wire sel_ier = addr_in == ADDR_IER;
  wire sel_iir = addr_in == ADDR_IIR;
  wire sel_lcr = addr_in == ADDR_LCR;
  wire sel_lsr = addr_in == ADDR_LSR;
  wire sel_xcr = addr_in == ADDR_XCR;
  wire wr_thr = wr_in && sel_dat && !divisor_access_select;
  wire wr_ier = wr_in && sel_ier && !divisor_access_select;
  wire wr_dll = wr_in && sel_dat && divisor_access_select;
  wire wr_dlm = wr_in && sel_ier && divisor_access_select;
  wire wr_xcr = wr_in && sel_xcr && divisor_access_select;
  // Write side of the shared address is queue control.
  wire wr_fcr = wr_in && sel_iir;
  wire rd_rbr = rd_in && sel_dat && !divisor_access_select;
  wire rd_iir = rd_in && sel_iir;
  wire rd_lsr = rd_in && sel_lsr;
  wire tx_flush = wr_fcr && wdata_in[FCR_TXF];
  wire rx_flush = wr_fcr && wdata_in[FCR_RXF];

  // Configuration registers.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dll  <= 8'h00;
      divisor_high_byte  <= 8'h00;
      baud_multiplier  <= XCR_RST;
      frame_format_control  <= LCR_RST;
      irq_enable_mask  <= 4'h0;
      trig <= TRIG_RST;
    end else begin
      // Divisor bytes only under divisor access.
      if (wr_dll) dll <= wdata_in;
      if (wr_dlm) divisor_high_byte <= wdata_in;
      if (wr_xcr) baud_multiplier <= wdata_in;
      if (wr_in && sel_lcr) frame_format_control <= wdata_in;
      if (wr_ier) irq_enable_mask <= wdata_in[3:0];
      if (wr_fcr) trig <= wdata_in[FCR_TRH:FCR_TRL];
    end
  end

  // Sample tick every divisor cycles; a bit is multiplier ticks long.
  wire [15:0] divisor  = {divisor_high_byte, dll};
  wire        samp     = (divisor != 16'h0000) &&
                         (div_cnt >= divisor - 16'h0001);
  wire [9:0]  bit_len  = {2'b00, baud_multiplier};
  wire [9:0]  half_len = {3'b000, baud_multiplier[7:1]};
  // Stop length of one or two bits.
  // Five-bit words with two stops use one and a half.
  wire [9:0]  stop_len = !frame_format_control[LCR_STB] ? bit_len :
                         (frame_format_control[1:0] == 2'h0) ? bit_len + half_len :
                         {bit_len[8:0], 1'b0};
  wire [2:0]  last_bit = MIN_BITS_M1 + {1'b0, frame_format_control[1:0]};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) div_cnt <= 16'h0000;
    else if (samp || divisor == 16'h0000) div_cnt <= 16'h0000;
    else div_cnt <= div_cnt + 16'h0001;
  end

  // Free-running bit-period tick, used only to time the idle timeout.
  wire bit_tick = samp && bt_cnt >= bit_len - 10'h001;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) bt_cnt <= 10'h000;
    else if (bit_tick) bt_cnt <= 10'h000;
    else if (samp) bt_cnt <= bt_cnt + 10'h001;
  end

  // Transmit queue.
  wire tx_load = tx_st == TX_IDLE && tx_cnt != 5'h00;
  // Sixteen-entry transmit queue; writes to a full queue are dropped.
  wire tx_push = wr_thr && tx_cnt != FIFO_FULL;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_wp  <= 4'h0;
      tx_rp  <= 4'h0;
      tx_cnt <= 5'h00;
    end else if (tx_flush) begin
      tx_wp  <= 4'h0;
      tx_rp  <= 4'h0;
      tx_cnt <= 5'h00;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 4'h1;
      if (tx_load) tx_rp <= tx_rp + 4'h1;
      tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_load};
    end
  end
  always_ff @(posedge clk_in) begin
    if (tx_push) tx_mem[tx_wp] <= wdata_in;
  end

  // Transmit shifter.
  wire [9:0] tx_len = (tx_st == TX_STOP) ? stop_len : bit_len;
  wire       tx_end = samp && tx_tcnt >= tx_len - 10'h001;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_st    <= TX_IDLE;
      tx_tcnt  <= 10'h000;
      tx_shift <= 8'h00;
      tx_bitn  <= 3'h0;
      tx_par   <= 1'b0;
    end else if (tx_flush) begin
      tx_st   <= TX_IDLE;
      tx_tcnt <= 10'h000;
    end else begin
      if (tx_end || tx_load) tx_tcnt <= 10'h000;
      else if (samp) tx_tcnt <= tx_tcnt + 10'h001;
      case (tx_st)
        TX_IDLE: if (tx_load) begin
          tx_shift <= tx_mem[tx_rp];
          tx_par   <= par_calc(tx_mem[tx_rp], frame_format_control);
          tx_st    <= TX_START;
        end
        TX_START: if (tx_end) begin
          tx_bitn <= 3'h0;
          tx_st   <= TX_DATA;
        end
        TX_DATA: if (tx_end) begin
          tx_shift <= {1'b0, tx_shift[7:1]};
          tx_bitn  <= tx_bitn + 3'h1;
          if (tx_bitn == last_bit)
            tx_st <= frame_format_control[LCR_PEN] ? TX_PAR : TX_STOP;
        end
        TX_PAR:  if (tx_end) tx_st <= TX_STOP;
        TX_STOP: if (tx_end) tx_st <= TX_IDLE;
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // Line level per frame phase, idle high.
  logic line_val;
  always_comb begin
    case (tx_st)
      TX_START: line_val = 1'b0;
      TX_DATA:  line_val = tx_shift[0];
      TX_PAR:   line_val = tx_par;
      default:  line_val = 1'b1;
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) txd_out <= 1'b1;
    else txd_out <= line_val && !frame_format_control[LCR_BRK];
  end

  // Receive line synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1   <= rxd_in;
      rx_s2   <= rx_s1;
      rx_prev <= rx_s2;
    end
  end

  wire       rx_mid  = samp && rx_tcnt >= half_len;
  wire       rx_full = samp && rx_tcnt >= bit_len - 10'h001;
  wire [7:0] rx_data = rx_shift >> (2'h3 - frame_format_control[1:0]);
  wire       rx_done = rx_st == RX_STOP && rx_full;
  // All-zero frame with low stop is a break.
  wire       rx_isbrk = rx_done && rx_allz && !rx_s2;
  wire       rx_fe   = !rx_s2 && !rx_isbrk;
  wire       rx_pe   = frame_format_control[LCR_PEN] && !rx_isbrk &&
                       (rx_par != par_calc(rx_data, frame_format_control));
  wire [10:0] rx_word = rx_isbrk ? {1'b1, 10'h000} :
                        {1'b0, rx_fe, rx_pe, rx_data};
  // A full queue keeps its contents.
  wire rx_push = rx_done && rx_cnt != FIFO_FULL;
  wire rx_pop  = rd_rbr && rx_cnt != 5'h00;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_st    <= RX_IDLE;
      rx_tcnt  <= 10'h000;
      rx_shift <= 8'h00;
      rx_bitn  <= 3'h0;
      rx_par   <= 1'b0;
      rx_allz  <= 1'b0;
    end else if (rx_flush) begin
      rx_st   <= RX_IDLE;
      rx_tcnt <= 10'h000;
    end else begin
      if (rx_st == RX_IDLE || rx_st == RX_BRK) rx_tcnt <= 10'h000;
      else if ((rx_st == RX_START) ? rx_mid : rx_full) rx_tcnt <= 10'h000;
      else if (samp) rx_tcnt <= rx_tcnt + 10'h001;
      case (rx_st)
        // Falling edge, then confirm low at mid-bit.
        RX_IDLE: if (rx_prev && !rx_s2) rx_st <= RX_START;
        RX_START: if (rx_mid) begin
          rx_st   <= rx_s2 ? RX_IDLE : RX_DATA;
          rx_bitn <= 3'h0;
          rx_allz <= 1'b1;
        end
        RX_DATA: if (rx_full) begin
          rx_shift <= {rx_s2, rx_shift[7:1]};
          rx_allz  <= rx_allz && !rx_s2;
          rx_bitn  <= rx_bitn + 3'h1;
          if (rx_bitn == last_bit)
            rx_st <= frame_format_control[LCR_PEN] ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rx_full) begin
          rx_par  <= rx_s2;
          rx_allz <= rx_allz && !rx_s2;
          rx_st   <= RX_STOP;
        end
        // After a break, wait for the line to return high.
        RX_STOP: if (rx_full) rx_st <= rx_isbrk ? RX_BRK : RX_IDLE;
        RX_BRK:  if (rx_s2) rx_st <= RX_IDLE;
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // Sixteen-entry receive queue carrying per-character flags.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_wp  <= 4'h0;
      rx_rp  <= 4'h0;
      rx_cnt <= 5'h00;
    end else if (rx_flush) begin
      rx_wp  <= 4'h0;
      rx_rp  <= 4'h0;
      rx_cnt <= 5'h00;
    end else begin
      if (rx_push) rx_wp <= rx_wp + 4'h1;
      if (rx_pop) rx_rp <= rx_rp + 4'h1;
      rx_cnt <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end
  always_ff @(posedge clk_in) begin
    if (rx_push) rx_mem[rx_wp] <= rx_word;
  end
  wire [10:0] rx_head = (rx_cnt != 5'h00) ? rx_mem[rx_rp] : 11'h000;

  // Head flags are latched after a pop with two or more characters queued, or a push into an empty queue.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) head_new <= 1'b0;
    else head_new <= !rx_flush && ((rx_pop && rx_cnt > 5'h01) ||
                                   (rx_push && rx_cnt == 5'h00));
  end

  // Line status flags; a setting event wins over a clearing read.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      oe_f  <= 1'b0;
      pe_f  <= 1'b0;
      fe_f  <= 1'b0;
      bi_f  <= 1'b0;
      err_f <= 1'b0;
    end else begin
      // Overrun on arrival into a full queue.
      oe_f  <= (rx_done && rx_cnt == FIFO_FULL) || (oe_f && !rd_lsr);
      // Parity error of the head character.
      pe_f  <= (head_new && rx_head[8]) || (pe_f && !rd_lsr);
      // Framing error of the head character.
      fe_f  <= (head_new && rx_head[9]) || (fe_f && !rd_lsr);
      bi_f  <= (head_new && rx_head[10]) || (bi_f && !rd_lsr);
      // Any error received since the last status read.
      err_f <= (rx_push && rx_word[10:8] != 3'h0) || (err_f && !rd_lsr);
    end
  end

  // Four character times without queue activity.
  wire [3:0] frame_bits = MIN_FRAME + {2'b00, frame_format_control[1:0]} +
                          {3'h0, frame_format_control[LCR_PEN]} + {3'h0, frame_format_control[LCR_STB]};
  wire [7:0] to_limit   = {2'b00, frame_bits, 2'b00};
  wire       to_hit     = rx_cnt != 5'h00 && to_cnt >= to_limit;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) to_cnt <= 8'h00;
    else if (rx_push || rx_pop || rx_flush || rx_cnt == 5'h00)
      to_cnt <= 8'h00;
    else if (bit_tick && !to_hit) to_cnt <= to_cnt + 8'h01;
  end

  // Transmit-empty source armed when the queue drains.
  wire tx_empty = tx_cnt == 5'h00;
  wire tx_queue_empty_ev  = tx_flush || (tx_load && tx_cnt == 5'h01 && !tx_push);
  logic [2:0] iid;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) tx_queue_empty_irq <= 1'b0;
    else tx_queue_empty_irq <= tx_queue_empty_ev ||
                     (tx_queue_empty_irq && !wr_thr && !(rd_iir && iid == IID_TE));
  end

  logic [4:0] trig_lvl;
  always_comb begin
    case (trig)
      2'h0:    trig_lvl = TRIG_L0;
      2'h1:    trig_lvl = TRIG_L1;
      2'h2:    trig_lvl = TRIG_L2;
      default: trig_lvl = TRIG_L3;
    endcase
  end

  wire src_ls = irq_enable_mask[IER_LS] && (oe_f || pe_f || fe_f || bi_f);
  wire src_ra = irq_enable_mask[IER_RA] && rx_cnt >= trig_lvl;
  wire src_to = irq_enable_mask[IER_RA] && to_hit;
  wire src_te = irq_enable_mask[IER_TE] && tx_queue_empty_irq && tx_empty;
  // This port has no modem lines, so the modem source never fires.
  wire src_ms = irq_enable_mask[IER_MS] && 1'b0;
  wire any_irq = src_ls || src_ra || src_to || src_te || src_ms;
  // Priority encoding of the pending source.
  always_comb begin
    if (src_ls) iid = IID_LS;
    else if (src_ra) iid = IID_RA;
    else if (src_to) iid = IID_TO;
    else if (src_te) iid = IID_TE;
    else iid = IID_MS;
  end

  wire tx_all_empty = tx_empty && tx_st == TX_IDLE;
  // Data ready while the queue holds a character.
  wire [7:0] lsr_val = {err_f, tx_all_empty, tx_empty, bi_f, fe_f, pe_f, oe_f,
                        rx_cnt != 5'h00};

  // Read data stands only in the cycle after the strobe.
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    // Data address returns the head character.
    if (sel_dat) rd_mux = divisor_access_select ? dll : rx_head[7:0];
    else if (sel_ier) rd_mux = divisor_access_select ? divisor_high_byte : {4'h0, irq_enable_mask};
    // Pending bit is low while a source is active.
    else if (sel_iir) rd_mux = {4'h0, iid, !any_irq};
    else if (sel_lcr) rd_mux = frame_format_control;
    else if (sel_lsr) rd_mux = lsr_val;
    else if (sel_xcr) rd_mux = divisor_access_select ? baud_multiplier : 8'h00;
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 8'h00;
      irq_out   <= 1'b0;
    end else begin
      rdata_out <= rd_in ? rd_mux : 8'h00;
      irq_out   <= any_irq;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_BREAK_LOW: assert property (frame_format_control[LCR_BRK] |=> !txd_out)
    else $error("break did not hold the line low");
  AST_RBR_DATA: assert property (
    rd_rbr && rx_cnt != 5'h00 |=> rdata_out == $past(rx_mem[rx_rp][7:0]))
    else $error("receive read returned wrong data");
  AST_DR_SET: assert property (
    rx_push && !rx_flush |=> lsr_val[0])
    else $error("data ready not set after a push");
  AST_PENDING: assert property (
    rd_iir && any_irq |=> !rdata_out[0] && rdata_out[3:1] == $past(iid))
    else $error("identification read wrong");
  AST_ERR_CLEAR: assert property (
    rd_lsr && !rx_push |=> !err_f)
    else $error("error summary not cleared by status read");
  AST_TX_ALL_EMPTY_WR: assert property (wr_thr |=> !lsr_val[6])
    else $error("transmitter empty still set after write");
  AST_TX_FLUSH: assert property (tx_flush |=> tx_cnt == 5'h00)
    else $error("transmit flush left data");
  AST_OVERRUN: assert property (
    rx_done && rx_cnt == FIFO_FULL && !rx_flush |=> oe_f && rx_cnt == FIFO_FULL)
    else $error("overrun not flagged or queue changed");
  AST_LS_FIRST: assert property (src_ls |-> iid == IID_LS)
    else $error("line status not given top priority");
endmodule : asp_uart

// ---- tb/asp_remote.sv ----
// Behavioural remote serial device that sends and captures line frames.
`timescale 1ns/1ps
module asp_remote #(
  parameter int BIT_CLKS = 4
) (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  logic [10:0] frame;
  int          rx_count;
  initial begin
    line_out = 1'b1;
    rx_count = 0;
  end
  // mid-bit capture.
  // Eleven slots cover the longest frame up to its first stop bit; later slots read idle high.
  initial begin
    forever begin
      @(negedge line_in);
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      for (int i = 0; i < 11; i++) begin
        #1 frame[i] = line_in;
        if (i < 10) repeat (BIT_CLKS) @(posedge clk_in);
      end
      rx_count++;
    end
  end
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
    line_out <= 1'b1;
    // The receiver pushes at mid stop bit, which for an eleven-slot frame is after the last slot has ended,
    // so idle for two bits before the caller looks at status or interrupt.
    repeat (2 * BIT_CLKS) @(posedge clk_in);
  endtask : send
endmodule : asp_remote

// ---- tb/tb_asp_uart.sv ----
// Self-checking bench for the asynchronous serial port.
`timescale 1ns/1ps
`define CHK(a, e) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end
module tb_asp_uart
  import asp_pkg::*;
;
  logic        clk, rst_b, wr, rd;
  logic [15:0] addr;
  logic [7:0]  wdata, lc, d, v;
  logic [10:0] f;
  logic [7:0]  q [17];
  wire  [7:0]  rdata;
  wire         txd, rxd, irq;
  int          bad_count, cmp_count, n;

  asp_uart DUT (.clk_in(clk), .rst_b_in(rst_b), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rxd_in(rxd),
    .rdata_out(rdata), .txd_out(txd), .irq_out(irq));
  // Divisor 1 and multiplier 4 give a four-clock bit.
  asp_remote #(.BIT_CLKS(4)) rem (.clk_in(clk), .line_in(txd),
    .line_out(rxd));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [10:0] frm(logic [7:0] x, logic [7:0] c);
    logic [10:0] r;
    logic [7:0]  m;
    m = 8'hFF >> (2'd3 - c[1:0]);
    r = '1;
    r[0] = 1'b0;
    for (int k = 0; k < 5 + c[1:0]; k++) r[k + 1] = x[k];
    if (c[3])
      r[6 + c[1:0]] = c[5] ? ~c[4] : (c[4] ? ^(x & m) : ~^(x & m));
    return r;
  endfunction : frm

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk);
    addr  <= a;
    wdata <= x;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 x = rdata;
  endtask : rd_reg

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] x;
    rd_reg(a, x);
    `CHK(x, e)
  endtask : chk_rd

  task automatic report_and_stop;
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(32'hC8FB));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    chk_rd(ADDR_LSR, 8'h60);
    chk_rd(ADDR_IIR, 8'h01);
    chk_rd(ADDR_LCR, LCR_RST);
    chk_rd(16'h2506, 8'h00);
    chk_rd(ADDR_XCR, 8'h00);
    wr_reg(ADDR_IER, 8'hFF);
    chk_rd(ADDR_IER, 8'h0F);
    wr_reg(ADDR_IER, 8'h00);
    wr_reg(ADDR_LCR, 8'h83);
    chk_rd(ADDR_XCR, XCR_RST);
    wr_reg(ADDR_DATA, 8'h01);
    wr_reg(ADDR_IER, 8'h5A);
    wr_reg(ADDR_XCR, 8'h04);
    chk_rd(ADDR_IER, 8'h5A);
    chk_rd(ADDR_DATA, 8'h01);
    wr_reg(ADDR_IER, 8'h00);
    wr_reg(ADDR_LCR, 8'h03);
    chk_rd(ADDR_IER, 8'h00);
    for (int i = 0; i < 12; i++) begin
      lc = {2'b00, 6'($urandom)};
      lc[1:0] = 2'(i);
      d = 8'($urandom);
      n = rem.rx_count;
      wr_reg(ADDR_LCR, lc);
      wr_reg(ADDR_DATA, d);
      rd_reg(ADDR_LSR, v);
      `CHK(v[6], 1'b0)
      for (int k = 0; k < 300 && rem.rx_count <= n; k++) @(posedge clk);
      `CHK(rem.frame, frm(d, lc))
      repeat (16) @(posedge clk);
      chk_rd(ADDR_LSR, 8'h60);
    end
    for (int i = 0; i < 8; i++) begin
      lc = {2'b00, 6'($urandom)};
      lc[1:0] = 2'(i);
      d = 8'($urandom) & (8'hFF >> (2'd3 - lc[1:0]));
      wr_reg(ADDR_LCR, lc);
      rem.send(frm(d, lc));
      chk_rd(ADDR_LSR, 8'h61);
      chk_rd(ADDR_DATA, d);
    end
    wr_reg(ADDR_LCR, 8'h1B);
    wr_reg(ADDR_IER, 8'h05);
    wr_reg(ADDR_IIR, 8'h00);
    f = frm(8'hA5, 8'h1B);
    f[9] = ~f[9];
    rem.send(f);
    `CHK(irq, 1'b1)
    chk_rd(ADDR_IIR, 8'h06);
    chk_rd(ADDR_LSR, 8'hE5);
    chk_rd(ADDR_IIR, 8'h04);
    chk_rd(ADDR_DATA, 8'hA5);
    chk_rd(ADDR_IIR, 8'h01);
    wr_reg(ADDR_LCR, 8'h03);
    f = frm(8'hA5, 8'h03);
    f[9] = 1'b0;
    rem.send(f);
    chk_rd(ADDR_LSR, 8'hE9);
    chk_rd(ADDR_DATA, 8'hA5);
    rem.send(11'h000);
    rd_reg(ADDR_LSR, v);
    `CHK(v & 8'hF7, 8'hF1)
    chk_rd(ADDR_DATA, 8'h00);
    chk_rd(ADDR_LSR, 8'h60);
    wr_reg(ADDR_IIR, 8'hC0);
    wr_reg(ADDR_IER, 8'h01);
    rem.send(frm(8'h3C, 8'h03));
    repeat (100) @(posedge clk);
    chk_rd(ADDR_IIR, 8'h01);
    repeat (120) @(posedge clk);
    chk_rd(ADDR_IIR, 8'h0C);
    chk_rd(ADDR_DATA, 8'h3C);
    chk_rd(ADDR_IIR, 8'h01);
    wr_reg(ADDR_IER, 8'h02);
    wr_reg(ADDR_DATA, 8'h81);
    repeat (60) @(posedge clk);
    `CHK(irq, 1'b1)
    chk_rd(ADDR_IIR, 8'h02);
    chk_rd(ADDR_IIR, 8'h01);
    wr_reg(ADDR_IER, 8'h00);
    for (int i = 0; i < 17; i++) begin
      q[i] = 8'($urandom);
      rem.send(frm(q[i], 8'h03));
    end
    chk_rd(ADDR_LSR, 8'h63);
    for (int i = 0; i < 16; i++) chk_rd(ADDR_DATA, q[i]);
    chk_rd(ADDR_LSR, 8'h60);
    rem.send(frm(8'h11, 8'h03));
    rem.send(frm(8'h22, 8'h03));
    wr_reg(ADDR_IIR, 8'h02);
    chk_rd(ADDR_LSR, 8'h60);
    wr_reg(ADDR_LCR, 8'h43);
    repeat (3) @(posedge clk);
    `CHK(txd, 1'b0)
    wr_reg(ADDR_LCR, 8'h03);
    repeat (3) @(posedge clk);
    `CHK(txd, 1'b1)
    report_and_stop();
  end
endmodule : tb_asp_uart
